// *** include/kaw_pkg.sv ***
/*
 * constants, packed carriers and timing counts for the keypad / atx / watchdog
 * command handler. assumes a 125 MHz module clock and an upstream framer that
 * hands over whole, crc-checked command packets.
 */
// Operation
// - command 0x17 data 1 drives first gpio high while a key event waits; 0 releases it
// - poll command 0x18 answers held, pressed-since and released-since key masks
// - key weights: up 01, confirm 02, abort 04, west 08, east 10, south 20
// - atx command 0x1c takes one to three bytes; first byte is function mask
// - optional second atx byte sets power pulse in 1/32 s units, default one second
// - optional third atx byte picks sense: 0 second gpio, 1 supply rail
// - reset enabled, host up, confirm held 4 s: 1 s reset pulse, lock, self reset
// - power-on enabled, host down, confirm 0.25 s: power pulse, message, self reset
// - power-off enabled, host up, abort held 4 s: power pulse, extend up to 5 s
// - blank-when-host-down set: blank display and backlight while sense is low
// - reset and power lines float when idle, driven only during a pulse
// - pulses drive low unless invert bits set; auto polarity overrides both bits
// - watchdog 0x1d: 0 disables, 1-255 resets host unless refed in time
// - watchdog off after power-up; host enables atx before relying on it
// - debug 0x1e answers 15 bytes with atx, watchdog, contrast and backlight
// - command 0x1f writes 1-16 characters at given column and row
// - command 0x21 sets 7-bit slave address 0-127, default 0x2a
// - up and down held together 4 s shows the current address
package kaw_pkg;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_KEYFLAG = 8'h17;
	localparam logic [7:0] CMD_POLL    = 8'h18;
	localparam logic [7:0] CMD_ATX     = 8'h1c;
	localparam logic [7:0] CMD_WDOG    = 8'h1d;
	localparam logic [7:0] CMD_DEBUG   = 8'h1e;
	localparam logic [7:0] CMD_TEXT    = 8'h1f;
	localparam logic [7:0] CMD_ADDR    = 8'h21;
	localparam logic [7:0] ACK_BIT     = 8'h40;
	localparam logic [4:0] DEBUG_LEN   = 5'h0f;
	localparam logic [4:0] POLL_LEN    = 5'h03;

	// ==========================================================
	// key bit positions
	localparam int KEY_UP_BIT      = 0;
	localparam int KEY_CONFIRM_BIT = 1;
	localparam int KEY_ABORT_BIT   = 2;
	localparam int KEY_WEST_BIT    = 3;
	localparam int KEY_EAST_BIT    = 4;
	localparam int KEY_SOUTH_BIT   = 5;

	// ==========================================================
	// atx function mask bits
	localparam int ATX_AUTO_POL_BIT     = 0;
	localparam int ATX_RST_INV_BIT      = 1;
	localparam int ATX_PWR_INV_BIT      = 2;
	localparam int BLANK_WHEN_HOST_DOWN = 4;
	localparam int ATX_KP_RESET_BIT     = 5;
	localparam int ATX_KP_PWRON_BIT     = 6;
	localparam int ATX_KP_PWROFF_BIT    = 7;

	// ==========================================================
	// reset values
	localparam logic [7:0] ATX_MASK_RST   = 8'h00;
	localparam logic       SENSE_SRC_RST  = 1'b1;
	localparam logic [6:0] SLAVE_ADDR_RST = 7'h2a;

	// ==========================================================
	// timing: everything slow is counted in 1/32 s ticks
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned TICK_PERIOD_US  = 31250;
	localparam int unsigned TICK_CYCLES_DEF = CLK_MHZ * TICK_PERIOD_US;
	localparam int unsigned HOLD_LONG_MS    = 4000;
	localparam int unsigned PRESS_SHORT_MS  = 250;
	localparam int unsigned RST_PULSE_MS    = 1000;
	localparam int unsigned EXT_MAX_MS      = 5000;
	localparam logic [7:0] HOLD_LONG_TICKS  = 8'(HOLD_LONG_MS * 1000 / TICK_PERIOD_US);
	localparam logic [7:0] PRESS_SHORT_TICKS = 8'(PRESS_SHORT_MS * 1000 / TICK_PERIOD_US);
	localparam logic [8:0] RST_PULSE_TICKS  = 9'(RST_PULSE_MS * 1000 / TICK_PERIOD_US);
	localparam logic [8:0] EXT_MAX_TICKS    = 9'(EXT_MAX_MS * 1000 / TICK_PERIOD_US);
	localparam logic [4:0] TICKS_PER_SEC    = 5'h1f;

	// ==========================================================
	// carriers, states and messages
	typedef struct packed {
		logic [7:0]       typ;
		logic [4:0]       len;
		logic [17:0][7:0] data;
	} kaw_cmd_t;

	typedef struct packed {
		logic [7:0]       typ;
		logic [4:0]       len;
		logic [14:0][7:0] data;
	} kaw_rsp_t;

	typedef struct packed {
		logic [3:0]       col;
		logic             row;
		logic [4:0]       cnt;
		logic [15:0][7:0] text;
	} kaw_disp_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RST  = 4'b0010,
		ST_PWR  = 4'b0100,
		ST_EXT  = 4'b1000
	} kaw_state_t;

	typedef enum logic [2:0] {
		MSG_NONE   = 3'h0,
		MSG_RESET  = 3'h1,
		MSG_PWRON  = 3'h2,
		MSG_PWROFF = 3'h3,
		MSG_ADDR   = 3'h4
	} kaw_msg_t;

endpackage

// *** rtl/kaw_cmd_top.sv ***
/*
 * keypad, atx switch and host watchdog command handler.
 * assumes: command packets arrive whole on mclk from the framer, one-cycle
 * cmd_valid; answers go back the same way; keys, sense and line levels are pins.
 */
`timescale 1ns/1ps
module kaw_cmd_top #(
	parameter int unsigned TICK_CYCLES = kaw_pkg::TICK_CYCLES_DEF
) (
	input  wire logic              mclk,            // module clock
	input  wire logic              reset_n,         // async reset
	input  wire logic              cmd_valid,       // packet strobe
	input  wire kaw_pkg::kaw_cmd_t cmd,             // packet
	output logic                   rsp_valid,       // answer strobe
	output kaw_pkg::kaw_rsp_t      rsp,             // answer packet
	output logic                   disp_wr,         // text write strobe
	output kaw_pkg::kaw_disp_t     disp,            // text write
	input  wire logic [5:0]        keys_in,         // keys, high = pressed
	input  wire logic              sense_gpio_in,   // second gpio sense
	input  wire logic              sense_rail_in,   // supply-rail sense
	input  wire logic              rst_line_in,     // reset line level
	input  wire logic              pwr_line_in,     // power line level
	output logic                   rst_line_out,    // reset drive level
	output logic                   rst_line_oe_n,   // reset drive enable
	output logic                   pwr_line_out,    // power drive level
	output logic                   pwr_line_oe_n,   // power drive enable
	output logic                   key_flag_out,    // first gpio level
	output logic                   key_flag_oe_n,   // first gpio enable
	input  wire logic [7:0]        user_contrast,   // debug byte 9
	input  wire logic [7:0]        compat_contrast, // debug byte 13
	input  wire logic [7:0]        key_backlight,   // debug byte 10
	input  wire logic [7:0]        lcd_backlight,   // debug byte 14
	output logic                   blank_display,   // blank screen
	output logic                   backlight_off,   // backlight off
	output logic [2:0]             msg_code,        // message shown
	output logic                   cmd_locked,      // commands ignored
	output logic                   self_reset,      // self reset pulse
	output logic [6:0]             slave_addr       // bus address
);
	import kaw_pkg::*;

	// ==========================================================
	// pin synchronisers
	localparam int SW = 10;
	logic [SW-1:0] sy1_reg, sy2_reg;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sy1_reg <= '0;
			sy2_reg <= '0;
		end else begin
			sy1_reg <= {keys_in, sense_gpio_in, sense_rail_in, rst_line_in, pwr_line_in};
			sy2_reg <= sy1_reg;
		end
	end
	logic [5:0] ks;
	logic       s_gpio, s_rail, s_rst, s_pwr;
	assign {ks, s_gpio, s_rail, s_rst, s_pwr} = sy2_reg;

	// ==========================================================
	// tick, key history and hold timers
	localparam int TW = $clog2(TICK_CYCLES);
	logic [TW-1:0] tick_reg, tick_next;
	logic [5:0]    held_reg, held_next, prs_reg, prs_next, rel_reg, rel_next;
	logic [7:0]    hc_reg, hc_next, ha_reg, ha_next, hu_reg, hu_next;
	logic          tick, poll_clr, both_ud;

	assign tick    = (tick_reg == TW'(TICK_CYCLES - 1));
	assign both_ud = ks[KEY_UP_BIT] & ks[KEY_SOUTH_BIT];

	always_comb begin
		tick_next = tick ? '0 : tick_reg + 1'b1;
		held_next = ks;
		// a fresh edge in the clearing cycle survives the clear
		prs_next  = (prs_reg & ~{6{poll_clr}}) | (ks & ~held_reg);
		rel_next  = (rel_reg & ~{6{poll_clr}}) | (~ks & held_reg);
		hc_next   = !ks[KEY_CONFIRM_BIT] ? '0 : (tick && hc_reg != 8'hff) ? hc_reg + 1'b1 : hc_reg;
		ha_next   = !ks[KEY_ABORT_BIT] ? '0 : (tick && ha_reg != 8'hff) ? ha_reg + 1'b1 : ha_reg;
		hu_next   = !both_ud ? '0 : (tick && hu_reg != 8'hff) ? hu_reg + 1'b1 : hu_reg;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_reg <= '0;
			held_reg <= '0;
			prs_reg  <= '0;
			rel_reg  <= '0;
			hc_reg   <= '0;
			ha_reg   <= '0;
			hu_reg   <= '0;
		end else begin
			tick_reg <= tick_next;
			held_reg <= held_next;
			prs_reg  <= prs_next;
			rel_reg  <= rel_next;
			hc_reg   <= hc_next;
			ha_reg   <= ha_next;
			hu_reg   <= hu_next;
		end
	end

	// hold events fire once, on the tick that reaches the threshold
	logic ev_conf_long, ev_conf_short, ev_abort_long, ev_ud_long;
	assign ev_conf_long  = tick && ks[KEY_CONFIRM_BIT] && hc_reg == HOLD_LONG_TICKS - 8'h01;
	assign ev_conf_short = tick && ks[KEY_CONFIRM_BIT] && hc_reg == PRESS_SHORT_TICKS - 8'h01;
	assign ev_abort_long = tick && ks[KEY_ABORT_BIT] && ha_reg == HOLD_LONG_TICKS - 8'h01;
	assign ev_ud_long    = tick && both_ud && hu_reg == HOLD_LONG_TICKS - 8'h01;

	// ==========================================================
	// command decode, atx sequencer and watchdog
	kaw_state_t state_reg, state_next;
	logic       self_after_reg, self_after_next, kr_en_reg, kr_en_next, src_reg, src_next;
	logic [7:0] mask_reg, mask_next, plen_reg, plen_next, wd_reg, wd_next;
	logic [4:0] wsec_reg, wsec_next;
	logic [8:0] pcnt_reg, pcnt_next;
	logic [6:0] addr_reg, addr_next;
	logic       rlvl_reg, rlvl_next, plvl_reg, plvl_next, show_addr_reg, show_addr_next;
	logic       rspv_next, dispv_next, self_next, sense, accept, wd_load;
	kaw_rsp_t   rsp_next;
	kaw_disp_t  disp_next;
	kaw_msg_t   msg_next;

	assign sense  = src_reg ? s_rail : s_gpio;
	// nothing is taken while the self reset wipes the state
	assign accept = cmd_valid && !self_reset &&
		!(self_after_reg && state_reg != ST_IDLE);

	always_comb begin
		state_next      = state_reg;
		self_after_next = self_after_reg;
		kr_en_next      = kr_en_reg;
		src_next        = src_reg;
		mask_next       = mask_reg;
		plen_next       = plen_reg;
		wd_next         = wd_reg;
		wsec_next       = wsec_reg;
		pcnt_next       = pcnt_reg;
		addr_next       = addr_reg;
		rlvl_next       = rlvl_reg;
		plvl_next       = plvl_reg;
		rspv_next       = 1'b0;
		rsp_next        = '0;
		dispv_next      = 1'b0;
		disp_next       = '0;
		self_next       = 1'b0;
		poll_clr        = 1'b0;
		wd_load         = 1'b0;
		show_addr_next  = show_addr_reg ? both_ud : ev_ud_long;
		rsp_next.typ    = cmd.typ | ACK_BIT;

		if (accept) begin
			unique case (cmd.typ)
				CMD_KEYFLAG: if (cmd.len == 5'h01 && cmd.data[0] <= 8'h01) begin
					kr_en_next = cmd.data[0][0];
					rspv_next  = 1'b1;
				end
				CMD_POLL: if (cmd.len == 5'h00) begin
					rsp_next.len     = POLL_LEN;
					rsp_next.data[0] = {2'b00, held_reg};
					rsp_next.data[1] = {2'b00, prs_reg};
					rsp_next.data[2] = {2'b00, rel_reg};
					poll_clr         = 1'b1;
					rspv_next        = 1'b1;
				end
				CMD_ATX: if (cmd.len >= 5'h01 && cmd.len <= 5'h03) begin
					mask_next = cmd.data[0];
					// a missing or zero length byte means one second
					plen_next = (cmd.len >= 5'h02 && cmd.data[1] != 8'h00) ?
						cmd.data[1] : 8'(RST_PULSE_TICKS);
					if (cmd.len == 5'h03 && cmd.data[2] <= 8'h01)
						src_next = cmd.data[2][0];
					rspv_next = 1'b1;
				end
				CMD_WDOG: if (cmd.len == 5'h01) begin
					wd_next   = cmd.data[0];
					wsec_next = '0;
					wd_load   = 1'b1;
					rspv_next = 1'b1;
				end
				CMD_DEBUG: if (cmd.len == 5'h00) begin
					rsp_next.typ      = CMD_DEBUG;
					rsp_next.len      = DEBUG_LEN;
					rsp_next.data[7]  = mask_reg;
					rsp_next.data[8]  = wd_reg;
					rsp_next.data[9]  = user_contrast;
					rsp_next.data[10] = key_backlight;
					rsp_next.data[11] = {7'h00, src_reg};
					rsp_next.data[13] = compat_contrast;
					rsp_next.data[14] = lcd_backlight;
					rspv_next         = 1'b1;
				end
				CMD_TEXT: if (cmd.len >= 5'h03 && cmd.len <= 5'h12 &&
						cmd.data[0] <= 8'h0f && cmd.data[1] <= 8'h01) begin
					disp_next.col  = cmd.data[0][3:0];
					disp_next.row  = cmd.data[1][0];
					disp_next.cnt  = cmd.len - 5'h02;
					disp_next.text = cmd.data[17:2];
					dispv_next     = 1'b1;
					rspv_next      = 1'b1;
				end
				CMD_ADDR: if (cmd.len == 5'h01 && cmd.data[0] <= 8'h7f) begin
					addr_next = cmd.data[0][6:0];
					rspv_next = 1'b1;
				end
				default: ;
			endcase
		end

		// watchdog counts whole seconds; a feed in the same cycle wins
		if (!wd_load && wd_reg != 8'h00 && tick) begin
			wsec_next = wsec_reg + 5'h01;
			if (wsec_reg == TICKS_PER_SEC) begin
				wd_next = wd_reg - 8'h01;
			end
		end

		// pulses latch their level at start; auto polarity drives against the idle level
		unique case (state_reg)
			ST_IDLE: begin
				pcnt_next = '0;
				rlvl_next = mask_reg[ATX_AUTO_POL_BIT] ? ~s_rst : mask_reg[ATX_RST_INV_BIT];
				plvl_next = mask_reg[ATX_AUTO_POL_BIT] ? ~s_pwr : mask_reg[ATX_PWR_INV_BIT];
				if (mask_reg[ATX_KP_RESET_BIT] && sense && ev_conf_long) begin
					state_next      = ST_RST;
					self_after_next = 1'b1;
				end else if (mask_reg[ATX_KP_PWRON_BIT] && !sense && ev_conf_short) begin
					state_next      = ST_PWR;
					self_after_next = 1'b1;
				end else if (mask_reg[ATX_KP_PWROFF_BIT] && sense && ev_abort_long) begin
					state_next      = ST_PWR;
					self_after_next = 1'b0;
				end else if (!wd_load && wd_reg == 8'h01 && tick && wsec_reg == TICKS_PER_SEC) begin
					state_next      = ST_RST;
					self_after_next = 1'b0;
				end
			end
			ST_RST: begin
				pcnt_next = pcnt_reg + (tick ? 9'h001 : 9'h000);
				if (tick && pcnt_reg == RST_PULSE_TICKS - 9'h001) begin
					state_next = ST_IDLE;
					self_next  = self_after_reg;
				end
			end
			ST_PWR: begin
				pcnt_next = pcnt_reg + (tick ? 9'h001 : 9'h000);
				if (tick && pcnt_reg == {1'b0, plen_reg} - 9'h001) begin
					pcnt_next = '0;
					if (!self_after_reg && ks[KEY_ABORT_BIT]) begin
						state_next = ST_EXT;
					end else begin
						state_next = ST_IDLE;
						self_next  = self_after_reg;
					end
				end
			end
			ST_EXT: begin
				pcnt_next = pcnt_reg + (tick ? 9'h001 : 9'h000);
				if (!ks[KEY_ABORT_BIT] || (tick && pcnt_reg == EXT_MAX_TICKS - 9'h001))
					state_next = ST_IDLE;
			end
		endcase

		// message follows the next state so it lines up with the line drive
		if (self_after_next && state_next == ST_RST)
			msg_next = MSG_RESET;
		else if (self_after_next && state_next == ST_PWR)
			msg_next = MSG_PWRON;
		else if (state_next == ST_PWR || state_next == ST_EXT)
			msg_next = MSG_PWROFF;
		else if (show_addr_next)
			msg_next = MSG_ADDR;
		else
			msg_next = MSG_NONE;

		// a self reset loads power-up values; keeps the async reset branch pure
		if (self_reset) begin
			state_next      = ST_IDLE;
			self_after_next = 1'b0;
			kr_en_next      = 1'b0;
			src_next        = SENSE_SRC_RST;
			mask_next       = ATX_MASK_RST;
			plen_next       = 8'(RST_PULSE_TICKS);
			wd_next         = 8'h00;
			wsec_next       = '0;
			pcnt_next       = '0;
			addr_next       = SLAVE_ADDR_RST;
			rlvl_next       = 1'b0;
			plvl_next       = 1'b0;
			show_addr_next  = 1'b0;
			rspv_next       = 1'b0;
			rsp_next        = '0;
			dispv_next      = 1'b0;
			disp_next       = '0;
			self_next       = 1'b0;
			msg_next        = MSG_NONE;
		end
	end

	// ==========================================================
	// state registers; a self reset restores power-up values, watchdog off
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg      <= ST_IDLE;
			self_after_reg <= 1'b0;
			kr_en_reg      <= 1'b0;
			src_reg        <= SENSE_SRC_RST;
			mask_reg       <= ATX_MASK_RST;
			plen_reg       <= 8'(RST_PULSE_TICKS);
			wd_reg         <= 8'h00;
			wsec_reg       <= '0;
			pcnt_reg       <= '0;
			addr_reg       <= SLAVE_ADDR_RST;
			rlvl_reg       <= 1'b0;
			plvl_reg       <= 1'b0;
			show_addr_reg  <= 1'b0;
			rsp_valid      <= 1'b0;
			rsp            <= '0;
			disp_wr        <= 1'b0;
			disp           <= '0;
			rst_line_out   <= 1'b0;
			rst_line_oe_n  <= 1'b1;
			pwr_line_out   <= 1'b0;
			pwr_line_oe_n  <= 1'b1;
			key_flag_out   <= 1'b0;
			key_flag_oe_n  <= 1'b1;
			blank_display  <= 1'b0;
			backlight_off  <= 1'b0;
			msg_code       <= MSG_NONE;
			cmd_locked     <= 1'b0;
			self_reset     <= 1'b0;
			slave_addr     <= SLAVE_ADDR_RST;
		end else begin
			state_reg      <= state_next;
			self_after_reg <= self_after_next;
			kr_en_reg      <= kr_en_next;
			src_reg        <= src_next;
			mask_reg       <= mask_next;
			plen_reg       <= plen_next;
			wd_reg         <= wd_next;
			wsec_reg       <= wsec_next;
			pcnt_reg       <= pcnt_next;
			addr_reg       <= addr_next;
			rlvl_reg       <= rlvl_next;
			plvl_reg       <= plvl_next;
			show_addr_reg  <= show_addr_next;
			rsp_valid      <= rspv_next;
			rsp            <= rsp_next;
			disp_wr        <= dispv_next;
			disp           <= disp_next;
			rst_line_out   <= rlvl_next;
			rst_line_oe_n  <= (state_next != ST_RST);
			pwr_line_out   <= plvl_next;
			pwr_line_oe_n  <= !(state_next == ST_PWR || state_next == ST_EXT);
			key_flag_out   <= |(prs_next | rel_next);
			key_flag_oe_n  <= !kr_en_next;
			blank_display  <= mask_next[BLANK_WHEN_HOST_DOWN] && !sense;
			backlight_off  <= mask_next[BLANK_WHEN_HOST_DOWN] && !sense;
			msg_code       <= msg_next;
			cmd_locked     <= (self_after_next && state_next != ST_IDLE) || self_next;
			self_reset     <= self_next;
			slave_addr     <= addr_next;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_ack_type: assert property (accept && cmd.typ == CMD_KEYFLAG && cmd.len == 5'h01 &&
		cmd.data[0] <= 8'h01 |=> rsp_valid && rsp.typ == 8'h57 && rsp.len == 5'h00)
		else $error("key flag ack malformed");
	a_poll_reply: assert property (rsp_valid && rsp.typ == 8'h58 |->
		rsp.len == 5'h03 && rsp.data[0] == {2'b00, $past(held_reg)})
		else $error("poll reply wrong");
	a_poll_clear: assert property (poll_clr |=> (prs_reg & ~$past(ks & ~held_reg)) == 6'h00)
		else $error("pressed mask not cleared");
	a_lines_idle: assert property (state_reg == ST_IDLE |-> rst_line_oe_n && pwr_line_oe_n)
		else $error("line driven while idle");
	a_pol_fixed: assert property ($fell(pwr_line_oe_n) && !$past(mask_reg[ATX_AUTO_POL_BIT]) |->
		pwr_line_out == $past(mask_reg[ATX_PWR_INV_BIT]))
		else $error("power polarity wrong");
	a_wd_hold: assert property (wd_reg == 8'h00 && !wd_load |=> wd_reg == 8'h00)
		else $error("watchdog started by itself");
	a_addr_set: assert property (accept && cmd.typ == CMD_ADDR && cmd.len == 5'h01 &&
		cmd.data[0] <= 8'h7f |=> slave_addr == $past(cmd.data[0][6:0]))
		else $error("slave address not taken");
	a_blank_down: assert property (mask_next[BLANK_WHEN_HOST_DOWN] && !sense &&
		!self_reset |=> blank_display && backlight_off)
		else $error("display not blanked");
	a_rst_lock: assert property (self_after_reg && state_reg == ST_RST |->
		cmd_locked ##1 !rsp_valid)
		else $error("commands taken during reset");

	c_poll:   cover property (rsp_valid && rsp.typ == 8'h58);
	c_rst:    cover property ($fell(rst_line_oe_n));
	c_pwr:    cover property ($fell(pwr_line_oe_n));
	c_text:   cover property (disp_wr);
endmodule

// *** testbench/kaw_host_model.sv ***
/* host side model: pulled-up power and reset wires, host power sense.
 * assumes each control line arrives as drive level plus active-low enable. */
`timescale 1ns/1ps
module kaw_host_model (
	input  wire logic rst_out,    // reset drive level
	input  wire logic rst_oe_n,   // reset enable
	input  wire logic pwr_out,    // power drive level
	input  wire logic pwr_oe_n,   // power enable
	input  wire logic host_on,    // host powered
	output logic      rst_lvl,    // reset wire
	output logic      pwr_lvl,    // power wire
	output logic      sense_gpio, // gpio sense
	output logic      sense_rail  // rail sense
);
	// ==========================================================
	// wires
	// a released line goes to the host pull-up, never the last driven level
	assign rst_lvl = rst_oe_n ? 1'b1 : rst_out;
	assign pwr_lvl = pwr_oe_n ? 1'b1 : pwr_out;
	// sense gpio set up as pull-up input, control gpios as hi-z inputs
	assign sense_gpio = host_on;
	assign sense_rail = host_on;
endmodule

// *** testbench/testbench.sv ***
/* self-checking bench for the keypad / atx / watchdog command handler.
 * assumes TICK_CYCLES of 8 so one second is 256 clocks. */
`timescale 1ns/1ps
module testbench;
	import kaw_pkg::*;
	logic mclk = 0, reset_n = 0, cmd_valid = 0, host_on = 1, rv, dw;
	logic rsp_valid, disp_wr, rst_o, rst_oe_n, pwr_o, pwr_oe_n, flag_o, flag_oe_n;
	logic blank, bl_off, locked, self_rst, s_gpio, s_rail, rst_lvl, pwr_lvl;
	logic [5:0] keys_in = '0;
	logic [2:0] msg;
	logic [6:0] addr;
	kaw_cmd_t cmd = '0;
	kaw_rsp_t rsp, r;
	kaw_disp_t disp, dd;
	int n_errors = 0, checks_done = 0, n;

	always #4 mclk = ~mclk;

	kaw_cmd_top #(.TICK_CYCLES(8)) u_dut (.mclk(mclk), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
		.disp_wr(disp_wr), .disp(disp), .keys_in(keys_in), .sense_gpio_in(s_gpio),
		.sense_rail_in(s_rail), .rst_line_in(rst_lvl), .pwr_line_in(pwr_lvl),
		.rst_line_out(rst_o), .rst_line_oe_n(rst_oe_n), .pwr_line_out(pwr_o),
		.pwr_line_oe_n(pwr_oe_n), .key_flag_out(flag_o), .key_flag_oe_n(flag_oe_n),
		.user_contrast(8'h11), .compat_contrast(8'h33), .key_backlight(8'h22),
		.lcd_backlight(8'h44), .blank_display(blank), .backlight_off(bl_off),
		.msg_code(msg), .cmd_locked(locked), .self_reset(self_rst), .slave_addr(addr));

	kaw_host_model u_host (.rst_out(rst_o), .rst_oe_n(rst_oe_n), .pwr_out(pwr_o),
		.pwr_oe_n(pwr_oe_n), .host_on(host_on), .rst_lvl(rst_lvl), .pwr_lvl(pwr_lvl),
		.sense_gpio(s_gpio), .sense_rail(s_rail));

	// ==========================================================
	// helpers
	task chk(input logic [127:0] got, input logic [127:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// one packet, answer captured in the cycle it stands
	task send(input logic [7:0] t, input logic [4:0] l, input logic [31:0] d);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= {t, l, 112'h0, d};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		#1;
		rv = rsp_valid;
		r = rsp;
		dw = disp_wr;
		dd = disp;
	endtask

	// ==========================================================
	// scenarios
	task t_keys;
		send(CMD_KEYFLAG, 5'h1, 32'h1);
		chk({rv, r.typ, r.len}, {1'b1, 8'h57, 5'h0});
		@(posedge mclk) keys_in <= 6'h01;
		repeat (6) @(posedge mclk);
		#1 chk({flag_oe_n, flag_o}, 2'b01);
		send(CMD_POLL, 5'h0, 32'h0);
		chk({r.typ, r.len, r.data[2:0]}, {8'h58, 5'h3, 24'h000101});
		@(posedge mclk) keys_in <= 6'h20;
		#1 chk(flag_o, 1'b0);
		repeat (6) @(posedge mclk);
		send(CMD_POLL, 5'h0, 32'h0);
		chk(r.data[2:0], 24'h012020);
		send(CMD_KEYFLAG, 5'h1, 32'h0);
		chk({rv, flag_oe_n}, 2'b11);
		$display("keys test done");
	endtask

	task t_cfg;
		send(CMD_DEBUG, 5'h0, 32'h0);
		chk({r.typ, r.len, r.data[8:7]}, {8'h1e, 5'hf, 16'h0});
		@(posedge mclk) host_on <= 1'b0;
		send(CMD_ATX, 5'h3, 32'h000510);
		chk({rv, r.typ}, {1'b1, 8'h5c});
		repeat (6) @(posedge mclk);
		#1 chk({blank, bl_off}, 2'b11);
		send(CMD_DEBUG, 5'h0, 32'h0);
		chk(r.data, {64'h4433_0000_2211_0010, 56'h0});
		@(posedge mclk) host_on <= 1'b1;
		send(CMD_ATX, 5'h4, 32'h0);
		chk(rv, 1'b0);
		$display("atx config test done");
	endtask

	task t_text_addr;
		send(CMD_TEXT, 5'h4, 32'h4241_0103);
		chk({dw, dd.col, dd.row, dd.cnt, dd.text[1:0]}, {11'h4e2, 16'h4241});
		send(CMD_TEXT, 5'h2, 32'h0);
		chk(rv, 1'b0);
		send(CMD_ADDR, 5'h1, 32'h80);
		chk(rv, 1'b0);
		send(CMD_ADDR, 5'h1, 32'h13);
		#8 chk({r.typ, addr}, {8'h61, 7'h13});
		$display("text and address test done");
	endtask

	task t_wdog;
		send(CMD_WDOG, 5'h1, 32'h1);
		chk(r.typ, 8'h5d);
		for (n = 0; n < 400 && rst_oe_n !== 1'b0; n++) #8;
		chk({n > 200, rst_oe_n, rst_o, locked}, 4'h8);
		for (n = 0; n < 400 && rst_oe_n !== 1'b1; n++) #8;
		chk({n > 200, rst_oe_n}, 2'b11);
		$display("watchdog test done");
	endtask

	task t_kreset;
		send(CMD_ATX, 5'h1, 32'h22);
		@(posedge mclk) keys_in <= 6'h02;
		#1;
		for (n = 0; n < 1300 && rst_oe_n !== 1'b0; n++) #8;
		chk({n > 1000, rst_o, msg, locked}, 6'h33);
		send(CMD_POLL, 5'h0, 32'h0);
		chk(rv, 1'b0);
		for (n = 0; n < 400 && self_rst !== 1'b1; n++) #8;
		#16 chk({rst_oe_n, addr}, {1'b1, 7'h2a});
		@(posedge mclk) keys_in <= 6'h00;
		$display("keypad reset test done");
	endtask

	task t_kpower;
		send(CMD_ATX, 5'h2, 32'h0481);
		@(posedge mclk) keys_in <= 6'h04;
		#1;
		for (n = 0; n < 1300 && pwr_oe_n !== 1'b0; n++) #8;
		chk({n > 1000, pwr_o, msg, rst_oe_n}, 6'h27);
		repeat (100) @(posedge mclk);
		#1 chk({pwr_oe_n, msg}, 4'h3);
		@(posedge mclk) keys_in <= 6'h00;
		repeat (6) @(posedge mclk);
		#1 chk({pwr_oe_n, pwr_lvl, msg}, 5'h18);
		@(posedge mclk) keys_in <= 6'h21;
		#1;
		for (n = 0; n < 1300 && msg !== 3'h4; n++) #8;
		chk({n > 1000, msg}, 4'hc);
		@(posedge mclk) keys_in <= 6'h00;
		$display("keypad power test done");
	endtask

	// ==========================================================
	// sequence and ending
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		t_keys;
		t_cfg;
		t_text_addr;
		t_wdog; // atx set up first
		t_kreset;
		t_kpower;
		test_done;
	end

	// whole run is near 4000 clocks
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done;
	end
endmodule
